// ===== rtl/dchannel_arbiter_rx_overflow.sv
// D-channel arbiter with receive FIFO of the first HDLC controller
module dchannel_arbiter_rx_overflow #(
  parameter int NUM_CHAN = dch_arb_pkg::NUM_CHAN,
  parameter int FIFO_DEPTH = dch_arb_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Configuration
  input wire logic control_channel_mode_in,
  input wire logic [NUM_CHAN-1:0] dchan_enable_regs_in,
  input wire logic [1:0] clock_mode_sel_in,
  // Command port
  input wire logic cmd_wr_in,
  input wire logic [7:0] command_reg_in,
  input wire logic rx_msg_end_ack_in,
  // Deframed receive link
  input wire dch_arb_pkg::rx_link_t link_in,
  // FIFO read side
  input wire logic fifo_rd_ready_in,
  output logic fifo_rd_valid_out,
  output dch_arb_pkg::fifo_word_t fifo_rd_data_out,
  // Channel arbitration outputs
  output logic [NUM_CHAN-1:0] chan_blocked_out,
  output logic [4:0] selected_chan_out,
  output dch_arb_pkg::arb_state_t arb_state_out,
  // Status and events
  output logic rx_msg_end_irq_out,
  output logic rx_frame_overflow_out,
  output logic stuck_receiving_out
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int HOLD_W = $clog2(dch_arb_pkg::LIMITED_HOLD_CYCLES + 1);

  if (NUM_CHAN < 1 || NUM_CHAN > 32) begin : g_bad_chan
    $error("NUM_CHAN must be 1..32");
  end

  // ============================================================
  // State
  typedef struct packed {
    dch_arb_pkg::arb_state_t arb;
    logic [4:0] sel;
    logic in_frame;
    logic fits;
    logic overflowed;
    logic [AW:0] frame_len;
    logic rme_pending;
    logic rfo_pulse;
    logic [HOLD_W-1:0] hold;
    logic [NUM_CHAN-1:0] blocked;
  } arb_all_t;

  arb_all_t state_reg;
  arb_all_t state_next;

  logic wr_valid;
  dch_arb_pkg::fifo_word_t wr_data;
  logic [AW:0] free;
  logic cmd_rmc;
  logic cmd_rhr;
  logic chan_en;
  logic status_room;

  function automatic logic [NUM_CHAN-1:0] block_mask(input logic [4:0] sel,
                                                     input logic [NUM_CHAN-1:0] en);
    logic [NUM_CHAN-1:0] m;
    m = en;
    m[sel] = 1'b0;
    return m;
  endfunction : block_mask

  assign cmd_rmc = cmd_wr_in && (command_reg_in == dch_arb_pkg::CMD_RX_MSG_COMPLETE);
  assign cmd_rhr = cmd_wr_in && command_reg_in[dch_arb_pkg::CMD_RX_RESET_BIT];
  assign chan_en = control_channel_mode_in && dchan_enable_regs_in[link_in.channel];
  // A full FIFO would drop the status byte even of an empty frame
  assign status_room = state_reg.fits && (free != '0);

  // ============================================================
  // FIFO write path: data bytes then the status byte
  always_comb begin
    wr_valid = 1'b0;
    wr_data = '0;
    if (state_reg.in_frame && link_in.channel == state_reg.sel && !state_reg.overflowed) begin
      if (link_in.byte_valid) begin
        wr_valid = 1'b1;
        wr_data.data = link_in.byte_data;
      end else if (link_in.frame_end && status_room) begin
        wr_valid = 1'b1;
        wr_data.data = 8'(state_reg.frame_len);
        wr_data.is_status = 1'b1;
      end
    end
  end

  rx_frame_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .wr_valid_in(wr_valid),
    .wr_data_in(wr_data),
    .rd_ready_in(fifo_rd_ready_in),
    .rd_valid_out(fifo_rd_valid_out),
    .rd_data_out(fifo_rd_data_out),
    .free_out(free)
  );

  // ============================================================
  // Arbiter
  always_comb begin
    state_next = state_reg;
    state_next.rfo_pulse = 1'b0;
    if (rx_msg_end_ack_in) begin
      state_next.rme_pending = 1'b0;
    end
    case (state_reg.arb)
      dch_arb_pkg::ST_SUSPENDED: begin
        state_next.blocked = '0;
        if (control_channel_mode_in) begin
          state_next.arb = dch_arb_pkg::ST_FULL_SEL;
        end
      end
      dch_arb_pkg::ST_FULL_SEL: begin
        state_next.blocked = '0;
        if (link_in.frame_start && chan_en) begin
          state_next.sel = link_in.channel;
          state_next.arb = dch_arb_pkg::ST_EXPECT_FRAME;
        end
      end
      dch_arb_pkg::ST_EXPECT_FRAME: begin
        state_next.blocked = block_mask(state_reg.sel, dchan_enable_regs_in);
        state_next.in_frame = 1'b1;
        state_next.fits = 1'b1;
        state_next.frame_len = '0;
        state_next.arb = dch_arb_pkg::ST_RECEIVE_FRAME;
      end
      dch_arb_pkg::ST_RECEIVE_FRAME: begin
        state_next.blocked = block_mask(state_reg.sel, dchan_enable_regs_in);
        if (link_in.channel == state_reg.sel) begin
          if (link_in.frame_start && state_reg.overflowed) begin
            state_next.rfo_pulse = 1'b1;
          end
          if (link_in.byte_valid && !state_reg.overflowed) begin
            state_next.frame_len = state_reg.frame_len + 1'b1;
            if (free <= (AW + 1)'(dch_arb_pkg::STATUS_BYTE_ROOM)) begin
              state_next.fits = 1'b0;
            end
          end
          if (link_in.frame_end && !state_reg.overflowed) begin
            state_next.in_frame = 1'b0;
            if (status_room) begin
              state_next.rme_pending = 1'b1;
              state_next.hold = '0;
              state_next.arb = dch_arb_pkg::ST_LIMITED_SEL;
            end else begin
              state_next.overflowed = 1'b1;
              state_next.rfo_pulse = 1'b1;
            end
          end
        end
        // Receiver reset deliberately leaves the arbiter alone
        if (cmd_rhr) begin
          state_next.in_frame = 1'b0;
        end
        if (cmd_rmc) begin
          state_next.in_frame = 1'b0;
          state_next.overflowed = 1'b0;
          state_next.rme_pending = 1'b1;
          state_next.hold = '0;
          state_next.arb = dch_arb_pkg::ST_LIMITED_SEL;
        end
      end
      dch_arb_pkg::ST_LIMITED_SEL: begin
        state_next.blocked = '0;
        state_next.overflowed = 1'b0;
        if (state_reg.hold == HOLD_W'(dch_arb_pkg::LIMITED_HOLD_CYCLES)) begin
          state_next.arb = dch_arb_pkg::ST_FULL_SEL;
        end else begin
          state_next.hold = state_reg.hold + 1'b1;
        end
        // Leaving limited selection on a new frame of another channel
        if (link_in.frame_start && chan_en && link_in.channel != state_reg.sel) begin
          state_next.sel = link_in.channel;
          state_next.arb = dch_arb_pkg::ST_EXPECT_FRAME;
        end
      end
      default: begin
        state_next.arb = dch_arb_pkg::ST_SUSPENDED;
      end
    endcase
    if (!control_channel_mode_in || clock_mode_sel_in != dch_arb_pkg::CLOCK_MODE_ARB) begin
      state_next.arb = dch_arb_pkg::ST_SUSPENDED;
      state_next.in_frame = 1'b0;
      state_next.overflowed = 1'b0;
      state_next.blocked = '0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // Outputs
  assign chan_blocked_out = state_reg.blocked;
  assign selected_chan_out = state_reg.sel;
  assign arb_state_out = state_reg.arb;
  assign rx_msg_end_irq_out = state_reg.rme_pending;
  assign rx_frame_overflow_out = state_reg.rfo_pulse;
  assign stuck_receiving_out = state_reg.overflowed;

endmodule : dchannel_arbiter_rx_overflow

// ===== rtl/dch_arb_pkg.sv
// Package: D-channel arbiter states, constants and carrier structs
// ============================================================
// Operation
// - With control-channel mode set, serve every D-channel marked in the enable registers.
// - From full selection, opening flag moves arbiter via expect-frame to receive-frame.
// - In receive-frame, received frame bytes are copied into the receive FIFO.
// - With room for frame plus one byte, frame end leads to limited selection.
// - Frame end reaches the arbiter only when the status byte is written.
// - No room for the status byte: no frame end, arbiter stays receiving.
// - Overflow arises: frame arrives without room while message-end interrupt is pending.
// - Stuck receiving, later frames of selected channel pass and raise overflow interrupt.
// - Stuck receiving, other channels stay blocked; the selected sender sees no blocking.
// - Clock-mode field other than 3 moves the arbiter to suspended.
// - Command value 80 gives receive-message-complete, internal frame end, limited selection.
// - Receiver-reset command does not reset the arbiter; it stays receiving.
package dch_arb_pkg;

  // ============================================================
  // Constants
  localparam int NUM_CHAN = 32;
  localparam int FIFO_DEPTH = 64;
  localparam logic [1:0] CLOCK_MODE_ARB = 2'h3;
  localparam logic [7:0] CMD_RX_MSG_COMPLETE = 8'h80;
  localparam int CMD_RX_RESET_BIT = 6;
  localparam int STATUS_BYTE_ROOM = 1;
  localparam int LIMITED_HOLD_TIME_NS = 1000;
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int LIMITED_HOLD_CYCLES =
      (LIMITED_HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ============================================================
  // Arbiter states
  typedef enum logic [2:0] {
    ST_SUSPENDED,
    ST_FULL_SEL,
    ST_EXPECT_FRAME,
    ST_RECEIVE_FRAME,
    ST_LIMITED_SEL
  } arb_state_t;

  // ============================================================
  // Carriers
  typedef struct packed {
    logic frame_start;
    logic byte_valid;
    logic [7:0] byte_data;
    logic frame_end;
    logic [4:0] channel;
  } rx_link_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_status;
  } fifo_word_t;

endpackage : dch_arb_pkg

// ===== rtl/rx_frame_fifo.sv
// Receive FIFO for the first HDLC controller, flip-flop storage
module rx_frame_fifo #(
  parameter int DEPTH = dch_arb_pkg::FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Write side
  input wire logic wr_valid_in,
  input wire dch_arb_pkg::fifo_word_t wr_data_in,
  // Read side
  input wire logic rd_ready_in,
  output logic rd_valid_out,
  output dch_arb_pkg::fifo_word_t rd_data_out,
  // Free space
  output logic [AW:0] free_out
);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rx_frame_fifo: DEPTH must be power of two >= 4");
  end

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    dch_arb_pkg::fifo_word_t out;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  dch_arb_pkg::fifo_word_t mem_reg [DEPTH];

  logic do_wr;
  logic do_rd;

  assign do_rd = rd_ready_in && (state_reg.count != '0);
  assign do_wr = wr_valid_in && (state_reg.count != (AW + 1)'(DEPTH) || do_rd);
  assign rd_valid_out = (state_reg.count != '0);
  assign rd_data_out = state_reg.out;
  assign free_out = (AW + 1)'(DEPTH) - state_reg.count;

  always_comb begin
    state_next = state_reg;
    if (do_wr) begin
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
    state_next.count = state_reg.count + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
    state_next.out = mem_reg[state_next.rd_ptr];
    if (do_wr && state_next.rd_ptr == state_reg.wr_ptr) begin
      state_next.out = wr_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (clk_en_in && do_wr) begin
      mem_reg[state_reg.wr_ptr] <= wr_data_in;
    end
  end

endmodule : rx_frame_fifo

// ===== testbench/dch_arb_props.sv
// Checker: state, blocking and recovery relations of the D-channel arbiter
module dch_arb_props #(
  parameter int NUM_CHAN = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Inputs watched
  input wire logic control_channel_mode_in,
  input wire logic [NUM_CHAN-1:0] dchan_enable_regs_in,
  input wire logic [1:0] clock_mode_sel_in,
  input wire logic cmd_wr_in,
  input wire logic [7:0] command_reg_in,
  input wire dch_arb_pkg::rx_link_t link_in,
  // Outputs watched
  input wire logic [NUM_CHAN-1:0] chan_blocked_out,
  input wire logic [4:0] selected_chan_out,
  input wire dch_arb_pkg::arb_state_t arb_state_out,
  input wire logic rx_msg_end_irq_out,
  input wire logic rx_frame_overflow_out,
  input wire logic stuck_receiving_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run;
  assign run = clk_en_in && control_channel_mode_in && clock_mode_sel_in == 2'h3;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // ============================================================
  // Assertions
  expect_on_start_a: assert property (
    run && arb_state_out == dch_arb_pkg::ST_FULL_SEL && link_in.frame_start
    && dchan_enable_regs_in[link_in.channel] |=> arb_state_out == dch_arb_pkg::ST_EXPECT_FRAME)
    else $error("no expect state");
  receive_follows_a: assert property (
    run && arb_state_out == dch_arb_pkg::ST_EXPECT_FRAME
    |=> arb_state_out == dch_arb_pkg::ST_RECEIVE_FRAME) else $error("no receive state");
  suspend_on_mode_a: assert property (
    clk_en_in && (clock_mode_sel_in != 2'h3 || !control_channel_mode_in)
    |=> arb_state_out == dch_arb_pkg::ST_SUSPENDED) else $error("not suspended");
  msg_complete_a: assert property (
    run && cmd_wr_in && command_reg_in == 8'h80 && arb_state_out == dch_arb_pkg::ST_RECEIVE_FRAME
    |=> arb_state_out == dch_arb_pkg::ST_LIMITED_SEL) else $error("no limited after command");
  rx_reset_keeps_a: assert property (
    run && cmd_wr_in && command_reg_in == 8'h40 && stuck_receiving_out && !link_in.frame_start
    |=> stuck_receiving_out && arb_state_out == dch_arb_pkg::ST_RECEIVE_FRAME)
    else $error("receiver reset left receive");
  stuck_in_receive_a: assert property (
    stuck_receiving_out |-> arb_state_out == dch_arb_pkg::ST_RECEIVE_FRAME)
    else $error("stuck outside receive");
  fit_end_irq_a: assert property (
    arb_state_out == dch_arb_pkg::ST_LIMITED_SEL
    && $past(arb_state_out) == dch_arb_pkg::ST_RECEIVE_FRAME |-> rx_msg_end_irq_out)
    else $error("frame end without interrupt");
  block_others_a: assert property (
    arb_state_out == dch_arb_pkg::ST_RECEIVE_FRAME |-> !chan_blocked_out[selected_chan_out]
    && chan_blocked_out == (dchan_enable_regs_in & ~(NUM_CHAN'(1) << selected_chan_out)))
    else $error("wrong blocking while receiving");
  overflow_pulse_a: assert property (
    run && stuck_receiving_out && link_in.frame_start && link_in.channel == selected_chan_out
    |-> ##[1:40] rx_frame_overflow_out) else $error("no overflow indication");
  cover property (stuck_receiving_out);
  cover property (rx_frame_overflow_out);
  cover property (arb_state_out == dch_arb_pkg::ST_LIMITED_SEL);
endmodule : dch_arb_props

bind dchannel_arbiter_rx_overflow dch_arb_props #(.NUM_CHAN(NUM_CHAN)) u_props (
  .clock_in, .rst_n_in, .clk_en_in, .control_channel_mode_in, .dchan_enable_regs_in,
  .clock_mode_sel_in, .cmd_wr_in, .command_reg_in, .link_in, .chan_blocked_out,
  .selected_chan_out, .arb_state_out, .rx_msg_end_irq_out, .rx_frame_overflow_out,
  .stuck_receiving_out);

// ===== testbench/hdlc_subscriber_model.sv
// Subscriber side: feeds deframed frames into the arbiter
module hdlc_subscriber_model (
  // Clock
  input wire logic clock_in,
  // Deframed link toward the arbiter
  output dch_arb_pkg::rx_link_t link_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial link_out = '0;
  // Kind bits: start, byte, end
  task automatic put(input logic [4:0] ch, input logic [2:0] kind, input logic [7:0] d);
    link_out.channel = ch;
    link_out.frame_start = kind[2];
    link_out.byte_valid = kind[1];
    link_out.frame_end = kind[0];
    link_out.byte_data = d;
    // Held past the edge; the next put, idle or not, replaces it
    @(posedge clock_in);
    #1;
  endtask : put
  task automatic frame(input logic [4:0] ch, input int len);
    put(ch, 3'h4, 8'h00);
    put(ch, 3'h0, 8'h00);
    for (int i = 0; i < len; i++) begin
      put(ch, 3'h2, 8'hA0 + 8'(i));
    end
    put(ch, 3'h1, 8'h00);
    put(ch, 3'h0, 8'h00);
  endtask : frame
endmodule : hdlc_subscriber_model

// ===== testbench/dchannel_arbiter_rx_overflow_bench.sv
// Testbench: D-channel arbiter with receive overflow and recovery
module dchannel_arbiter_rx_overflow_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] EN = 32'h0000_00FF;
  logic clock_in = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b1;
  logic [1:0] cm = 2'h3;
  logic cmd_wr = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic ack = 1'b0;
  logic rd_ready = 1'b0;
  logic clk_en = 1'b1;
  int n_ovf = 0;
  dch_arb_pkg::rx_link_t link;
  dch_arb_pkg::fifo_word_t rd_data;
  dch_arb_pkg::arb_state_t arb;
  logic rd_valid, irq, ovf, stuck;
  logic [31:0] blk;
  logic [4:0] sel;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  always #25 clock_in = ~clock_in;
  dchannel_arbiter_rx_overflow #(.FIFO_DEPTH(8)) u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n), .clk_en_in(clk_en), .control_channel_mode_in(mode),
    .dchan_enable_regs_in(EN), .clock_mode_sel_in(cm), .cmd_wr_in(cmd_wr),
    .command_reg_in(cmd), .rx_msg_end_ack_in(ack), .link_in(link), .fifo_rd_ready_in(rd_ready),
    .fifo_rd_valid_out(rd_valid), .fifo_rd_data_out(rd_data), .chan_blocked_out(blk),
    .selected_chan_out(sel), .arb_state_out(arb), .rx_msg_end_irq_out(irq),
    .rx_frame_overflow_out(ovf), .stuck_receiving_out(stuck));
  hdlc_subscriber_model u_sub (.clock_in(clock_in), .link_out(link));
  // ============================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_full;
    for (int i = 0; i < 40 && arb !== dch_arb_pkg::ST_FULL_SEL; i++) tick();
    check("state", arb, dch_arb_pkg::ST_FULL_SEL);
  endtask : wait_full
  task automatic restart;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    wait_full();
  endtask : restart
  task automatic command(input logic [7:0] c);
    cmd = c;
    cmd_wr = 1'b1;
    tick();
    cmd_wr = 1'b0;
  endtask : command
  // ============================================================
  // Scenarios
  task automatic fit_frame;
    u_sub.put(5'd3, 3'h4, 8'h00);
    check("state", arb, dch_arb_pkg::ST_EXPECT_FRAME);
    check("selected", sel, 32'd3);
    u_sub.put(5'd3, 3'h0, 8'h00);
    check("state", arb, dch_arb_pkg::ST_RECEIVE_FRAME);
    check("blocked", blk, EN & ~32'h8);
    for (int i = 0; i < 4; i++) u_sub.put(5'd3, 3'h2, 8'hA0 + 8'(i));
    u_sub.put(5'd3, 3'h1, 8'h00);
    check("state", arb, dch_arb_pkg::ST_LIMITED_SEL);
    check("irq", irq, 32'd1);
    u_sub.put(5'd3, 3'h0, 8'h00);
    // Ready held high: one word popped at every edge
    rd_ready = 1'b1;
    for (int i = 0; i <= 4; i++) begin
      check("valid", rd_valid, 32'd1);
      check("word", rd_data, i < 4 ? {8'hA0 + 8'(i), 1'b0} : 9'h009);
      tick();
    end
    rd_ready = 1'b0;
    check("valid", rd_valid, 32'd0);
    ack = 1'b1;
    tick();
    ack = 1'b0;
    check("irq", irq, 32'd0);
    wait_full();
  endtask : fit_frame
  task automatic overflow_stuck;
    int base;
    restart();
    u_sub.frame(5'd3, 4);
    wait_full();
    check("irq", irq, 32'd1);
    base = n_ovf;
    u_sub.frame(5'd5, 4);
    check("stuck", stuck, 32'd1);
    check("state", arb, dch_arb_pkg::ST_RECEIVE_FRAME);
    check("blocked", blk, EN & ~32'h20);
    check("overflow", n_ovf - base, 32'd1);
    u_sub.frame(5'd5, 2);
    check("overflow", n_ovf - base, 32'd2);
    command(8'h40);
    tick(2);
    check("state", arb, dch_arb_pkg::ST_RECEIVE_FRAME);
    check("stuck", stuck, 32'd1);
    command(8'h80);
    check("state", arb, dch_arb_pkg::ST_LIMITED_SEL);
    check("stuck", stuck, 32'd0);
    check("irq", irq, 32'd1);
  endtask : overflow_stuck
  task automatic clock_mode_exit;
    restart();
    u_sub.frame(5'd2, 12);
    check("stuck", stuck, 32'd1);
    cm = 2'h2;
    tick();
    check("state", arb, dch_arb_pkg::ST_SUSPENDED);
    cm = 2'h3;
    wait_full();
    check("stuck", stuck, 32'd0);
  endtask : clock_mode_exit
  task automatic mode_and_enable;
    restart();
    u_sub.frame(5'd9, 2);
    check("state", arb, dch_arb_pkg::ST_FULL_SEL);
    mode = 1'b0;
    tick();
    check("state", arb, dch_arb_pkg::ST_SUSPENDED);
    mode = 1'b1;
    wait_full();
    // Enable low: a clock-mode change must not act until it returns
    clk_en = 1'b0;
    cm = 2'h2;
    tick(2);
    check("state", arb, dch_arb_pkg::ST_FULL_SEL);
    clk_en = 1'b1;
    tick();
    check("state", arb, dch_arb_pkg::ST_SUSPENDED);
    cm = 2'h3;
    wait_full();
  endtask : mode_and_enable
  // ============================================================
  // Run control
  always @(posedge clock_in) begin
    if (ovf) n_ovf++;
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    tick(2);
    rst_n = 1'b1;
    wait_full();
    fit_frame();
    overflow_stuck();
    clock_mode_exit();
    mode_and_enable();
    wrap_up();
  end
endmodule : dchannel_arbiter_rx_overflow_bench
